/* lcd_serial_cmd_frontend.sv */
// Serial command/data front end of an LCD controller
`timescale 1ns/1ps
`include "lcd_fe_map.svh"

module lcd_serial_cmd_frontend
   import lcd_fe_pkg::*;
#(
   parameter logic [`FE_FRAME_W-1:0] FRAME_TICKS = `FE_FRAME_TICKS
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic si_pin,
   input wire logic sck_pin,
   input wire logic cmd_sel_pin,
   input wire logic cs_n_pin,
   input wire logic reset_n_pin,
   input wire logic sync_in,
   input wire logic decode_on,
   input wire logic div4_mode,
   output logic busy_n_o,
   output logic busy_n_oe,
   output logic sync_o,
   output logic sync_oe,
   output logic [`FE_BYTE_W-1:0] cmd_byte,
   output logic cmd_valid,
   output logic [`FE_MEM_DEPTH*`FE_NIB_W-1:0] disp_latch,
   output logic [`FE_PHASE_W-1:0] com_phase
);

   // ==========================================================
   // State and decoder
   fe_state_t q_ff;
   fe_state_t nxt_q;
   logic [`FE_PAT_W-1:0] dec_pattern;
   logic [`FE_NCNT_W-1:0] dec_count;
   logic sck_rise;
   logic cs_fall;
   logic cs_rise;
   logic cs_low;
   logic accept;
   logic sync_fall;

   // Decoder looks at the latched data byte
   seg_decoder u_dec (
      .data(q_ff.cd_byte),
      .div4_mode(div4_mode),
      .pattern(dec_pattern),
      .nib_count(dec_count)
   );

   // Pick one nibble of a decoded pattern
   function automatic logic [`FE_NIB_W-1:0] nib_sel(
      input logic [`FE_PAT_W-1:0] pat,
      input logic [`FE_NCNT_W-1:0] idx
   );
      logic [`FE_NIB_W-1:0] r;
      r = pat[4'(idx) * 4 +: 4];
      return r;
   endfunction : nib_sel

   // ==========================================================
   // Edge detection on synchronised pins
   assign sck_rise = q_ff.pin_s2[`FE_PIN_SCK] & ~q_ff.pin_d[`FE_PIN_SCK];
   assign cs_fall = ~q_ff.pin_s2[`FE_PIN_CS] & q_ff.pin_d[`FE_PIN_CS];
   assign cs_rise = q_ff.pin_s2[`FE_PIN_CS] & ~q_ff.pin_d[`FE_PIN_CS];
   assign cs_low = ~q_ff.pin_s2[`FE_PIN_CS];
   assign sync_fall = ~q_ff.pin_s2[`FE_PIN_SYNC] & q_ff.pin_d[`FE_PIN_SYNC];
   // Shift edge counts only when selected, not held, idle
   assign accept = sck_rise & cs_low & q_ff.busy_n & (q_ff.phase == ST_SHIFT);

   // ==========================================================
   // Next state
   always_comb begin
      nxt_q = q_ff;
      nxt_q.pin_s1 = {sync_in, reset_n_pin, cs_n_pin, cmd_sel_pin, sck_pin, si_pin};
      nxt_q.pin_s2 = q_ff.pin_s1;
      nxt_q.pin_d = q_ff.pin_s2;
      nxt_q.cmd_valid = 1'b0;
      case (q_ff.phase)
         ST_SHIFT: begin
            if (accept) begin
               // Shift in at the right (bit 0), MSB arrives first
               nxt_q.shreg = {q_ff.shreg[`FE_BYTE_W-2:0], q_ff.pin_s2[`FE_PIN_SI]};
               nxt_q.bit_cnt = q_ff.bit_cnt + 3'h1;
               if (q_ff.bit_cnt == `FE_CNT_LAST) begin
                  // Overflow: hold input, latch byte and its kind
                  nxt_q.busy_n = 1'b0;
                  nxt_q.cd_byte = {q_ff.shreg[`FE_BYTE_W-2:0], q_ff.pin_s2[`FE_PIN_SI]};
                  nxt_q.cd_cmd = q_ff.pin_s2[`FE_PIN_CD];
                  nxt_q.got_bytes = 1'b1;
                  nxt_q.phase = ST_LATCH;
               end
            end
         end
         ST_LATCH: begin
            if (q_ff.cd_cmd) begin
               // Command byte to the command decoder
               nxt_q.cmd_byte = q_ff.cd_byte;
               nxt_q.cmd_valid = 1'b1;
               nxt_q.busy_n = 1'b1;
               nxt_q.bit_cnt = '0;
               nxt_q.phase = ST_SHIFT;
            end else if (!decode_on) begin
               // Direct data nibble, pointer steps on
               nxt_q.mem[q_ff.ptr] = q_ff.cd_byte[`FE_NIB_W-1:0];
               nxt_q.ptr = q_ff.ptr + `FE_PTR_STEP;
               nxt_q.busy_n = 1'b1;
               nxt_q.bit_cnt = '0;
               nxt_q.phase = ST_SHIFT;
            end else if (dec_count == `FE_NIBS_NONE) begin
               // No pattern in this mode: byte dropped
               nxt_q.busy_n = 1'b1;
               nxt_q.bit_cnt = '0;
               nxt_q.phase = ST_SHIFT;
            end else begin
               // Decoded data goes through the segment decoder
               nxt_q.pattern = dec_pattern;
               nxt_q.wr_cnt = dec_count;
               nxt_q.wr_idx = '0;
               nxt_q.phase = ST_WRITE;
            end
         end
         ST_WRITE: begin
            // One nibble per cycle at successive addresses
            nxt_q.mem[q_ff.ptr] = nib_sel(q_ff.pattern, q_ff.wr_idx);
            nxt_q.ptr = q_ff.ptr + `FE_PTR_STEP;
            nxt_q.wr_idx = q_ff.wr_idx + 3'h1;
            if (q_ff.wr_idx == q_ff.wr_cnt - 3'h1) begin
               nxt_q.busy_n = 1'b1;
               nxt_q.bit_cnt = '0;
               nxt_q.phase = ST_SHIFT;
            end
         end
         default: begin
            nxt_q.phase = ST_SHIFT;
         end
      endcase
      // Select falling edge restarts the transfer
      if (cs_fall) begin
         nxt_q.bit_cnt = '0;
         nxt_q.busy_n = 1'b1;
         nxt_q.ptr = `FE_PTR_RST;
         nxt_q.phase = ST_SHIFT;
      end
      // Select rising edge shows new memory on the panel
      if (cs_rise && q_ff.got_bytes) begin
         nxt_q.disp = nxt_q.mem;
         nxt_q.got_bytes = 1'b0;
      end
      // Hold output driven only while selected
      nxt_q.busy_oe = cs_low;
      // Lockstep pin and common timing
      nxt_q.osc_div = q_ff.osc_div + 2'h1;
      if (!q_ff.pin_s2[`FE_PIN_RST]) begin
         // Base clock over four drives the lockstep pin
         nxt_q.sync_oe = 1'b1;
         nxt_q.sync_o = q_ff.osc_div[`FE_OSC_DIV_W-1];
         nxt_q.frame_cnt = '0;
         nxt_q.com_phase = '0;
      end else begin
         if (q_ff.frame_cnt == FRAME_TICKS - 8'h01) begin
            nxt_q.frame_cnt = '0;
            nxt_q.com_phase = q_ff.com_phase + 2'h1;
         end else begin
            nxt_q.frame_cnt = q_ff.frame_cnt + 8'h01;
         end
         // Another chip pulled the line: align to its common
         if (sync_fall && q_ff.com_phase != '0) begin
            nxt_q.frame_cnt = '0;
            nxt_q.com_phase = '0;
         end
         // Open-drain low during common phase zero, wired-OR
         nxt_q.sync_o = 1'b0;
         nxt_q.sync_oe = (nxt_q.com_phase == '0);
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge mclk) begin
      if (rst) begin
         q_ff <= '0;
         q_ff.pin_s1 <= 6'h3E;
         q_ff.pin_s2 <= 6'h3E;
         q_ff.pin_d <= 6'h3E;
         q_ff.phase <= ST_SHIFT;
         q_ff.busy_n <= 1'b1;
         q_ff.ptr <= `FE_PTR_RST;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // ==========================================================
   // Outputs straight from the state register
   assign busy_n_o = q_ff.busy_n;
   assign busy_n_oe = q_ff.busy_oe;
   assign sync_o = q_ff.sync_o;
   assign sync_oe = q_ff.sync_oe;
   assign cmd_byte = q_ff.cmd_byte;
   assign cmd_valid = q_ff.cmd_valid;
   assign disp_latch = q_ff.disp;
   assign com_phase = q_ff.com_phase;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence s_accept;
      accept;
   endsequence

   sequence s_last_bit;
      accept && q_ff.bit_cnt == `FE_CNT_LAST;
   endsequence

   sequence s_rst_held;
      !q_ff.pin_s2[`FE_PIN_RST] [*4];
   endsequence

   sequence s_dec_start;
      q_ff.phase == ST_LATCH && !q_ff.cd_cmd && decode_on && dec_count != '0;
   endsequence

   a_shift_count: assert property (
      s_accept |=> q_ff.bit_cnt == 3'($past(q_ff.bit_cnt) + 3'h1))
      else $error("pulse counter did not step on accepted edge");

   a_shift_msb: assert property (
      s_accept |=> q_ff.shreg[0] == $past(q_ff.pin_s2[`FE_PIN_SI])
         && q_ff.shreg[7:1] == $past(q_ff.shreg[6:0]))
      else $error("shift register did not take the input bit");

   a_overflow_hold: assert property (
      s_last_bit |=> !busy_n_o && q_ff.phase == ST_LATCH
         && q_ff.cd_cmd == $past(q_ff.pin_s2[`FE_PIN_CD]))
      else $error("eighth pulse did not hold input");

   a_held_ignore: assert property (
      (!q_ff.busy_n && !cs_fall) |=> $stable(q_ff.shreg) && $stable(q_ff.bit_cnt))
      else $error("shift register moved while held");

   a_cs_fall_clear: assert property (
      cs_fall |=> q_ff.ptr == `FE_PTR_RST && q_ff.bit_cnt == '0 && busy_n_o)
      else $error("select fall did not restart transfer");

   a_hold_float: assert property (
      cs_rise |=> !busy_n_oe)
      else $error("hold output driven while deselected");

   a_disp_copy: assert property (
      (cs_rise && q_ff.got_bytes) |=> q_ff.disp == q_ff.mem && !q_ff.got_bytes)
      else $error("display latch not loaded on select rise");

   a_cmd_forward: assert property (
      (q_ff.phase == ST_LATCH && q_ff.cd_cmd && !cs_fall)
         |=> cmd_valid && cmd_byte == $past(q_ff.cd_byte) && busy_n_o)
      else $error("command byte not forwarded");

   a_direct_ptr: assert property (
      (q_ff.phase == ST_LATCH && !q_ff.cd_cmd && !decode_on && !cs_fall)
         |=> q_ff.ptr == 5'($past(q_ff.ptr) + `FE_PTR_STEP) && busy_n_o)
      else $error("direct data did not advance pointer");

   a_dec_release: assert property (
      s_dec_start |=> q_ff.phase == ST_WRITE ##[1:4] busy_n_o)
      else $error("decoded write did not finish in time");

   a_sync_div4: assert property (
      s_rst_held |-> sync_oe && sync_o != $past(sync_o, 2))
      else $error("lockstep pin not at base clock over four");

   a_desel_ignore: assert property (
      (sck_rise && !cs_low) |=> $stable(q_ff.shreg) && $stable(q_ff.bit_cnt))
      else $error("shift edge taken while deselected");

   a_sync_align: assert property (
      (sync_fall && q_ff.com_phase != '0 && q_ff.pin_s2[`FE_PIN_RST])
         |=> com_phase == '0)
      else $error("common timing not aligned to lockstep line");

endmodule : lcd_serial_cmd_frontend

/* lcd_fe_map.svh */
// Constants of the serial command front end: widths, pin slots, reset values, counts
`ifndef LCD_FE_MAP_SVH
`define LCD_FE_MAP_SVH

// ==========================================================
// Data path widths
`define FE_BYTE_W 8
`define FE_CNT_W 3
`define FE_CNT_LAST 3'h7
`define FE_NIB_W 4
`define FE_MEM_DEPTH 32
`define FE_PTR_W 5
`define FE_PTR_RST 5'h00
`define FE_PTR_STEP 5'h01
`define FE_SEL_BIT 7
`define FE_PAT_W 16
`define FE_NCNT_W 3

// ==========================================================
// Nibble counts per decoded character
`define FE_NIBS_7SEG_DIV3 3'h3
`define FE_NIBS_7SEG_DIV4 3'h2
`define FE_NIBS_14SEG 3'h4
`define FE_NIBS_NONE 3'h0

// ==========================================================
// Slots of the pin synchroniser vector
`define FE_PINS 6
`define FE_PIN_SI 0
`define FE_PIN_SCK 1
`define FE_PIN_CD 2
`define FE_PIN_CS 3
`define FE_PIN_RST 4
`define FE_PIN_SYNC 5

// ==========================================================
// Lockstep timing: base clock over four, frame length in cycles
`define FE_OSC_DIV_W 2
`define FE_FRAME_W 8
`define FE_FRAME_TICKS 8'h80
`define FE_PHASE_W 2

`endif

/* lcd_fe_pkg.sv */
// Types of the serial command front end
`include "lcd_fe_map.svh"

package lcd_fe_pkg;

   // Byte handling phases
   typedef enum logic [1:0] {ST_SHIFT, ST_LATCH, ST_WRITE} fe_phase_t;

   // Whole state of the front end
   typedef struct packed {
      logic [`FE_PINS-1:0] pin_s1;
      logic [`FE_PINS-1:0] pin_s2;
      logic [`FE_PINS-1:0] pin_d;
      fe_phase_t phase;
      logic [`FE_BYTE_W-1:0] shreg;
      logic [`FE_CNT_W-1:0] bit_cnt;
      logic [`FE_BYTE_W-1:0] cd_byte;
      logic cd_cmd;
      logic [`FE_PTR_W-1:0] ptr;
      logic [`FE_NCNT_W-1:0] wr_idx;
      logic [`FE_NCNT_W-1:0] wr_cnt;
      logic [`FE_PAT_W-1:0] pattern;
      logic [`FE_MEM_DEPTH-1:0][`FE_NIB_W-1:0] mem;
      logic [`FE_MEM_DEPTH-1:0][`FE_NIB_W-1:0] disp;
      logic got_bytes;
      logic busy_n;
      logic busy_oe;
      logic [`FE_BYTE_W-1:0] cmd_byte;
      logic cmd_valid;
      logic [`FE_OSC_DIV_W-1:0] osc_div;
      logic sync_o;
      logic sync_oe;
      logic [`FE_PHASE_W-1:0] com_phase;
      logic [`FE_FRAME_W-1:0] frame_cnt;
   } fe_state_t;

endpackage : lcd_fe_pkg

/* seg_decoder.sv */
// Segment decoder: data byte to display nibbles and nibble count
`timescale 1ns/1ps
`include "lcd_fe_map.svh"

module seg_decoder
   import lcd_fe_pkg::*;
(
   input wire logic [`FE_BYTE_W-1:0] data,
   input wire logic div4_mode,
   output logic [`FE_PAT_W-1:0] pattern,
   output logic [`FE_NCNT_W-1:0] nib_count
);

   // ==========================================================
   // Pattern tables, nibble N in the low bits
   localparam logic [11:0] SEG7_D3 [0:15] = '{
      12'h353, 12'h003, 12'h271, 12'h073, 12'h123, 12'h172, 12'h372, 12'h013,
      12'h373, 12'h173, 12'h020, 12'h370, 12'h350, 12'h060, 12'h262, 12'h000};
   localparam logic [7:0] SEG7_D4 [0:15] = '{
      8'hD7, 8'h06, 8'hE3, 8'hA7, 8'h36, 8'hB5, 8'hF5, 8'h07,
      8'hF7, 8'hB7, 8'h20, 8'hF1, 8'hD1, 8'hA0, 8'hE4, 8'h00};
   localparam logic [15:0] SEG14 [0:63] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0002,
      16'h000A, 16'h5000, 16'hF00F, 16'hA005, 16'h0000, 16'h2004, 16'h0000, 16'h4002,
      16'h47E2, 16'h0600, 16'h23C4, 16'h2784, 16'h2624, 16'h25A4, 16'h25E4, 16'h0700,
      16'h27E4, 16'h27A4, 16'h0000, 16'h0000, 16'h4082, 16'h2084, 16'h1088, 16'h0000,
      16'hA7C0, 16'h2764, 16'h8785, 16'h01E0, 16'h8781, 16'h21E4, 16'h2164, 16'h05E4,
      16'h2664, 16'h8181, 16'h06C0, 16'h206A, 16'h00E0, 16'h1662, 16'h1668, 16'h07E0,
      16'h2364, 16'h07E8, 16'h236C, 16'h1584, 16'h8101, 16'h06E0, 16'h4062, 16'h4668,
      16'h500A, 16'h9002, 16'h4182, 16'h0000, 16'h1008, 16'h0000, 16'h0000, 16'h0000};

   // Table select by the top bit, pattern per mode
   always_comb begin
      pattern = '0;
      nib_count = `FE_NIBS_NONE;
      if (!data[`FE_SEL_BIT]) begin
         if (div4_mode) begin
            pattern = {8'h00, SEG7_D4[data[3:0]]};
            nib_count = `FE_NIBS_7SEG_DIV4;
         end else begin
            pattern = {4'h0, SEG7_D3[data[3:0]]};
            nib_count = `FE_NIBS_7SEG_DIV3;
         end
      end else if (div4_mode && data[6:5] != 2'h0) begin
         pattern = SEG14[6'(data[6:0] - 7'h20)];
         nib_count = `FE_NIBS_14SEG;
      end
   end

endmodule : seg_decoder

/* lcd_host_model.sv */
// Host model that drives the serial pins of the front end
`timescale 1ns/1ps

module lcd_host_model (
   input wire logic mclk,
   input wire logic busy_line,
   output logic si_pin,
   output logic sck_pin,
   output logic cmd_sel_pin,
   output logic cs_n_pin
);
   // ==========================================================
   // Idle levels: clock high, deselected
   initial begin
      si_pin = 1'b0;
      sck_pin = 1'b1;
      cmd_sel_pin = 1'b0;
      cs_n_pin = 1'b1;
   end

   // ==========================================================
   // Chip select change, then time for the synchronisers
   task automatic select(input logic lvl);
      @(negedge mclk);
      cs_n_pin = lvl;
      repeat (6) @(negedge mclk);
   endtask : select

   // Top n bits of b, most significant first, phases of 3 to 4 cycles
   task automatic send_bits(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         repeat (3) @(negedge mclk);
         sck_pin = 1'b0;
         si_pin = b[i];
         repeat (4) @(negedge mclk);
         sck_pin = 1'b1;
      end
   endtask : send_bits

   // Whole byte; ok when the hold output went low and came back high
   task automatic send_byte(input logic [7:0] b, input logic cmd, output logic ok);
      @(negedge mclk);
      cmd_sel_pin = cmd;
      send_bits(b, 8);
      ok = 1'b0;
      for (int k = 0; k < 20 && !ok; k++) begin
         @(negedge mclk);
         if (busy_line === 1'b0) ok = 1'b1;
      end
      for (int k = 0; k < 40 && ok && busy_line !== 1'b1; k++) @(negedge mclk);
      if (busy_line !== 1'b1) ok = 1'b0;
   endtask : send_byte
endmodule : lcd_host_model

/* tb_lcd_serial_cmd_frontend.sv */
// Testbench of the serial command front end against a bench model
`timescale 1ns/1ps
`include "lcd_fe_map.svh"

module tb_lcd_serial_cmd_frontend;
   localparam logic [`FE_FRAME_W-1:0] TICKS = 8'h04;
   logic mclk, rst, reset_n_pin, decode_on, div4_mode;
   logic busy_n_o, busy_n_oe, sync_o, sync_oe, cmd_valid, cmd_seen, ok, s, peer_pull;
   logic si_pin, sck_pin, cmd_sel_pin, cs_n_pin;
   logic [`FE_BYTE_W-1:0] cmd_byte, b;
   logic [`FE_MEM_DEPTH*`FE_NIB_W-1:0] disp_latch, prev;
   logic [`FE_PHASE_W-1:0] com_phase;
   logic [15:0] p;
   wire busy_line;
   wire sync_line;
   int error_cnt, num_checks, ptr_m, n;
   int mem_m[32];

   // ==========================================================
   // Pull-up on the hold line while floating; open-drain lockstep line
   assign busy_line = busy_n_oe ? busy_n_o : 1'b1;
   assign sync_line = (peer_pull || (sync_oe && !sync_o)) ? 1'b0 : 1'b1;

   lcd_serial_cmd_frontend #(.FRAME_TICKS(TICKS)) dut_u (
      .mclk(mclk), .rst(rst), .si_pin(si_pin), .sck_pin(sck_pin),
      .cmd_sel_pin(cmd_sel_pin), .cs_n_pin(cs_n_pin), .reset_n_pin(reset_n_pin),
      .sync_in(sync_line), .decode_on(decode_on), .div4_mode(div4_mode),
      .busy_n_o(busy_n_o), .busy_n_oe(busy_n_oe), .sync_o(sync_o), .sync_oe(sync_oe),
      .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .disp_latch(disp_latch),
      .com_phase(com_phase)
   );

   lcd_host_model host_u (
      .mclk(mclk), .busy_line(busy_line), .si_pin(si_pin), .sck_pin(sck_pin),
      .cmd_sel_pin(cmd_sel_pin), .cs_n_pin(cs_n_pin)
   );

   // ==========================================================
   // Clock and command pulse monitor
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   always @(posedge cmd_valid) cmd_seen = 1'b1;

   // ==========================================================
   // Compare, model helpers, closing task
   task automatic check(input logic [127:0] got, input logic [127:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic put(input logic [3:0] v);
      mem_m[ptr_m] = v;
      ptr_m = (ptr_m + 1) % 32;
   endtask : put

   function automatic logic [127:0] exp_disp();
      logic [127:0] v;
      for (int k = 0; k < 32; k++) v[4*k +: 4] = mem_m[k][3:0];
      return v;
   endfunction : exp_disp

   // Nibbles from address N upward, low nibble first
   function automatic logic [15:0] pat(input logic [7:0] d, input logic d4);
      if (d[7]) return (d4 && d[6:0] == 7'h30) ? 16'h47E2 : 16'h0000;
      case (d[3:0])
         4'h0: return d4 ? 16'h00D7 : 16'h0353;
         4'h1: return d4 ? 16'h0006 : 16'h0003;
         4'h2: return d4 ? 16'h00E3 : 16'h0271;
         default: return d4 ? 16'h00A7 : 16'h0073;
      endcase
   endfunction : pat

   task automatic xfer(input logic [7:0] d, input logic cmd);
      cmd_seen = 1'b0;
      host_u.send_byte(d, cmd, ok);
      check(128'(ok), 128'h1);
   endtask : xfer

   task automatic results();
      $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   // Watchdog
   initial begin
      #400000;
      error_cnt++;
      results();
   end

   // ==========================================================
   // Test sequence
   initial begin
      rst = 1'b1;
      reset_n_pin = 1'b1;
      decode_on = 1'b0;
      div4_mode = 1'b0;
      error_cnt = 0;
      num_checks = 0;
      peer_pull = 1'b0;
      ptr_m = 0;
      cmd_seen = 1'b0;
      foreach (mem_m[k]) mem_m[k] = 0;
      void'($urandom(94030));
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      check(disp_latch, 128'h0);
      check(128'({busy_n_oe, cmd_byte}), 128'h0);
      $display("Test reset done");
      // Stray edges while deselected, then commands
      host_u.send_bits(8'($urandom), 3);
      host_u.select(1'b0);
      check(128'({busy_n_oe, busy_n_o}), 128'h3);
      for (int i = 0; i < 4; i++) begin
         b = 8'($urandom);
         // Mode levels and device reset must not disturb commands
         {decode_on, div4_mode, reset_n_pin} = 3'($urandom);
         xfer(b, 1'b1);
         check(128'({cmd_seen, cmd_byte}), 128'({1'b1, b}));
      end
      host_u.select(1'b1);
      check(128'(busy_n_oe), 128'h0);
      decode_on = 1'b0;
      reset_n_pin = 1'b1;
      $display("Test commands done");
      // Partial byte aborted, then direct data past the pointer wrap
      host_u.select(1'b0);
      host_u.send_bits(8'($urandom), 3);
      host_u.select(1'b1);
      host_u.select(1'b0);
      prev = exp_disp();
      ptr_m = 0;
      for (int i = 0; i < 34; i++) begin
         b = 8'($urandom);
         xfer(b, 1'b0);
         put(b[3:0]);
      end
      check(disp_latch, prev);
      host_u.select(1'b1);
      check(disp_latch, exp_disp());
      $display("Test direct data done");
      // Decoded data in both multiplexing modes
      decode_on = 1'b1;
      for (int m = 0; m < 2; m++) begin
         div4_mode = m[0];
         host_u.select(1'b0);
         ptr_m = 0;
         for (int d = 0; d < 5; d++) begin
            b = (d == 4) ? 8'hB0 : {1'b0, 3'($urandom), 4'(d)};
            xfer(b, 1'b0);
            p = pat(b, m[0]);
            n = b[7] ? (m * 4) : (3 - m);
            for (int j = 0; j < n; j++) put(p[4*j +: 4]);
         end
         host_u.select(1'b1);
         check(disp_latch, exp_disp());
      end
      $display("Test decoder done");
      // Lockstep pin during and after device reset
      reset_n_pin = 1'b0;
      repeat (8) @(negedge mclk);
      n = 0;
      for (int i = 0; i < 16; i++) begin
         s = sync_o;
         @(negedge mclk);
         if (sync_o !== s) n++;
      end
      check(128'({sync_oe, 5'(n)}), 128'({1'b1, 5'd8}));
      reset_n_pin = 1'b1;
      n = 0;
      for (int i = 0; i < 60; i++) begin
         @(negedge mclk);
         if (com_phase === 2'h3) n++;
      end
      check(128'(n > 0), 128'h1);
      // Another chip pulls the line mid-frame: commons realign
      for (int i = 0; i < 20 && com_phase !== 2'h2; i++) @(negedge mclk);
      peer_pull = 1'b1;
      repeat (3) @(negedge mclk);
      check(128'(com_phase), 128'h0);
      peer_pull = 1'b0;
      $display("Test lockstep done");
      results();
   end
endmodule : tb_lcd_serial_cmd_frontend
